//--- mpc_carrier.sv
`timescale 1ns/1ps
module mpc_carrier #(
   parameter PG_DLY = 1
) (
   input  wire ref_clk,
   input  wire main_supply_on_n,
   input  wire pgHoldLow,
   input  wire pressReq,
   output wire power_good_in,
   output wire power_button_n
);
   // ****
   // Carrier rails and button
   // ****
   wire      psOn = ~main_supply_on_n;
   reg [3:0] railCnt_reg;
   always @(posedge ref_clk) begin
      if (!psOn)
         railCnt_reg <= 4'h0;
      else if (railCnt_reg != 4'hF)
         railCnt_reg <= railCnt_reg + 4'h1;
   end
   // Driven high when ready, never released to a pull-up
   assign power_good_in = !pgHoldLow && psOn && railCnt_reg >= PG_DLY;
   assign power_button_n = !pressReq;
endmodule

//--- mpc_power_control.v
`timescale 1ns/1ps
`include "mpc_regs.vh"
module mpc_power_control #(
   parameter RAIL_CYC  = `MPC_RAIL_CYC,
   parameter FORCE_CYC = `MPC_FORCE_CYC
) (
   input  wire       ref_clk,
   input  wire       arst_n,
   input  wire       power_good_in,
   input  wire       power_button_n,
   input  wire       sleepReq,
   input  wire [1:0] sleepTarget,
   input  wire       deepSleepEn,
   input  wire       wakeEvent,
   input  wire       buttonOffEn,
   output reg        main_supply_on_n,
   output reg        moduleReset_n,
   output reg        deepSleepActive,
   output reg        contextKept,
   output reg  [1:0] sleepState
);
   // ************************************************
   // Synchronizers
   // ************************************************
   wire pgSync;
   wire btnSync_n;
   mpc_sync2 #(.RESET_VAL(1'b0)) uPg (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .din     (power_good_in),
      .dout    (pgSync)
   ); // R15
   mpc_sync2 #(.RESET_VAL(1'b1)) uBtn (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .din     (power_button_n),
      .dout    (btnSync_n)
   ); // R15

   // ************************************************
   // Button edge and long hold
   // ************************************************
   reg        btnPrev_reg;
   reg [31:0] holdCnt_reg;
   wire       btnPress = btnPrev_reg & ~btnSync_n;
   wire       btnForce = (holdCnt_reg == FORCE_CYC[31:0] - 32'h1) & ~btnSync_n;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         btnPrev_reg <= 1'b1;
         holdCnt_reg <= 32'h0;
      end else begin
         btnPrev_reg <= btnSync_n;
         if (btnSync_n)
            holdCnt_reg <= 32'h0;
         else if (holdCnt_reg != FORCE_CYC[31:0])
            holdCnt_reg <= holdCnt_reg + 32'h1;
      end
   end

   // ************************************************
   // Power state machine
   // ************************************************
   localparam ST_OFF   = 5'h01;
   localparam ST_RAMP  = 5'h02;
   localparam ST_ON    = 5'h04;
   localparam ST_SLEEP = 5'h08;
   localparam ST_DEEP  = 5'h10;

   reg [4:0]  state_reg;
   reg [4:0]  state_next;
   reg [31:0] cnt_reg;
   reg [1:0]  entrySx_reg;

   // ************************************************
   // Request decode
   // ************************************************
   wire rampDone = (cnt_reg == RAIL_CYC[31:0] - 32'h1);
   wire inOn     = (state_reg == ST_ON);
   // Long hold always forces off; a short press only when enabled
   wire offReq   = btnForce | (btnPress & buttonOffEn);
   // S5 request is a soft off; S0 request is ignored
   wire softOff  = sleepReq & (sleepTarget == `MPC_SX_S5);
   wire sleepGo  = sleepReq & (sleepTarget != `MPC_SX_S0) & ~softOff;
   wire wakeGo   = btnPress | wakeEvent;

   // ************************************************
   // Next state
   // ************************************************
   // Requests outside their state are ignored
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (btnPress)
               state_next = ST_RAMP; // R10
         end
         ST_RAMP: begin
            if (rampDone)
               state_next = ST_ON;
         end
         ST_ON: begin
            if (offReq)
               state_next = ST_OFF; // R10
            else if (softOff)
               state_next = ST_OFF;
            else if (sleepGo)
               state_next = ST_SLEEP; // R14
         end
         ST_SLEEP: begin
            // Wake from S4 skips the ramp; reset waits for power-good
            if (wakeGo)
               state_next = ST_ON;
            else if (deepSleepEn)
               state_next = ST_DEEP; // R11
         end
         ST_DEEP: begin
            // Wake lands in the entry sleep state, not in S0
            if (wakeGo)
               state_next = ST_SLEEP; // R13
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   // ************************************************
   // State, ramp counter and entry state
   // ************************************************
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_OFF;
         cnt_reg   <= 32'h0;
      end else begin
         state_reg <= state_next;
         // Count runs only while ramping
         if (state_reg == ST_RAMP)
            cnt_reg <= cnt_reg + 32'h1;
         else
            cnt_reg <= 32'h0;
      end
   end

   // Latched so deep sleep can resume into it
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         entrySx_reg <= `MPC_SX_S5;
      else if (inOn && state_next == ST_SLEEP)
         entrySx_reg <= sleepTarget; // R13
   end

   // ************************************************
   // Output next values
   // ************************************************
   reg       supplyOn_next;
   reg       resetRel_next;
   reg       deep_next;
   reg       ctx_next;
   reg [1:0] sx_next;
   // The ON cycle sees the new target; the latch still holds the old one
   wire [1:0] sleepSx = inOn ? sleepTarget : entrySx_reg;
   wire       s3Entry = (sleepSx == `MPC_SX_S3);

   always @* begin
      supplyOn_next = 1'b0;
      resetRel_next = 1'b0;
      deep_next     = 1'b0;
      ctx_next      = 1'b0;
      sx_next       = `MPC_SX_S5;
      case (state_next)
         ST_RAMP: begin
            supplyOn_next = 1'b1; // R07
         end
         ST_ON: begin
            supplyOn_next = 1'b1; // R07
            // Held while power-good low; an undriven pin reads high
            resetRel_next = pgSync; // R02 R03 R06
            sx_next       = `MPC_SX_S0;
         end
         ST_SLEEP: begin
            // Supply held on in S3 so RAM keeps its content
            supplyOn_next = s3Entry; // R07 R14
            // Only S3 entry keeps context
            ctx_next      = s3Entry; // R12
            sx_next       = sleepSx; // R13
         end
         ST_DEEP: begin
            // Rails dropped; only wake logic stays powered
            deep_next     = 1'b1; // R11
            ctx_next      = s3Entry; // R12
            sx_next       = sleepSx; // R13
         end
         default: begin
            sx_next       = `MPC_SX_S5;
         end
      endcase
   end

   // ************************************************
   // Registered outputs
   // ************************************************
   // Flops keep the supply and reset pins free of decode glitches
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // Supply off and module held in reset
         main_supply_on_n <= 1'b1;
         moduleReset_n    <= 1'b0;
         deepSleepActive  <= 1'b0;
         contextKept      <= 1'b0;
         sleepState       <= `MPC_SX_S5;
      end else begin
         main_supply_on_n <= ~supplyOn_next; // R07
         moduleReset_n    <= resetRel_next; // R02 R03
         deepSleepActive  <= deep_next; // R11
         contextKept      <= ctx_next; // R12
         sleepState       <= sx_next; // R13
      end
   end
endmodule

//--- mpc_power_control_asserts.sv
`timescale 1ns/1ps
`include "mpc_regs.vh"
module mpc_power_control_asserts (
   input wire       ref_clk,
   input wire       arst_n,
   input wire       power_good_in,
   input wire       power_button_n,
   input wire       sleepReq,
   input wire [1:0] sleepTarget,
   input wire       deepSleepEn,
   input wire       wakeEvent,
   input wire       buttonOffEn,
   input wire       main_supply_on_n,
   input wire       moduleReset_n,
   input wire       deepSleepActive,
   input wire       contextKept,
   input wire [1:0] sleepState
);
   // ****
   // Windows fit rail counts of 1 to 11 only
   // ****
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_pg_low_reset: assert property ((!power_good_in) [*4] |-> !moduleReset_n)
      else $error("reset left with power good low");
   a_ramp_release: assert property ($fell(main_supply_on_n) |->
      (!moduleReset_n) [*4] ##[1:8] moduleReset_n) else $error("ramp timing");
   a_press_on: assert property ($fell(power_button_n) && sleepState == `MPC_SX_S5
      |-> ##[2:6] !main_supply_on_n) else $error("press did not power on");
   a_press_off: assert property ($fell(power_button_n) && buttonOffEn && moduleReset_n
      && sleepState == `MPC_SX_S0 |-> ##[2:6] main_supply_on_n) else $error("press off");
   a_s3_entry: assert property ($rose(contextKept) |->
      sleepState == `MPC_SX_S3 && !main_supply_on_n) else $error("s3 entry");
   a_deep_context: assert property (deepSleepActive |->
      contextKept == (sleepState == `MPC_SX_S3)) else $error("deep context");
   a_deep_resume: assert property ($fell(deepSleepActive) |->
      $stable(sleepState) && sleepState != `MPC_SX_S0) else $error("deep resume");
   a_s4_off: assert property (sleepState == `MPC_SX_S4 |->
      main_supply_on_n && !contextKept) else $error("s4 state");
endmodule
bind mpc_power_control mpc_power_control_asserts chk (.*);

//--- mpc_power_control_bench.sv
`timescale 1ns/1ps
`include "mpc_regs.vh"
module mpc_power_control_bench;
   reg        ref_clk = 1'b0, arst_n = 1'b0, pgHoldLow = 1'b0, pressReq = 1'b0;
   reg        sleepReq = 1'b0, deepSleepEn = 1'b0, wakeEvent = 1'b0, buttonOffEn = 1'b0;
   reg  [1:0] sleepTarget = 2'h0;
   wire       power_good_in, power_button_n, main_supply_on_n, moduleReset_n;
   wire       deepSleepActive, contextKept;
   wire [1:0] sleepState;
   integer    n_fail = 0, checked = 0, cycles = 0;
   // ****
   // Harness
   // ****
   always #10 ref_clk = ~ref_clk;
   mpc_carrier CAR (.*);
   mpc_power_control #(.RAIL_CYC(4), .FORCE_CYC(8)) DUT (.*);
   task cyc(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   task chk(input c);
      begin
         checked = checked + 1;
         if (c !== 1'b1) begin
            n_fail = n_fail + 1;
            $display("BAD %0t check %0d", $time, checked);
         end
      end
   endtask
   task finish_test;
      begin
         if (n_fail == 0 && checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         n_fail = n_fail + 1;
         $display("BAD %0t timeout", $time);
         finish_test;
      end
   end
   task press;
      begin
         pressReq = 1'b1;
         cyc(3);
         pressReq = 1'b0;
         cyc(2);
      end
   endtask
   task enter(input [1:0] s);
      begin
         sleepTarget = s;
         sleepReq = 1'b1;
         cyc(1);
         sleepReq = 1'b0;
         cyc(1);
      end
   endtask
   task wake;
      begin
         wakeEvent = 1'b1;
         cyc(1);
         wakeEvent = 1'b0;
         cyc(1);
      end
   endtask
   task t_power_up;
      begin
         press;
         chk(main_supply_on_n === 1'b0 && moduleReset_n === 1'b0);
         repeat (20) if (moduleReset_n !== 1'b1) cyc(1);
         chk(moduleReset_n === 1'b1 && sleepState === `MPC_SX_S0);
      end
   endtask
   task t_pg_drop;
      begin
         pgHoldLow = 1'b1;
         cyc(5);
         chk(moduleReset_n === 1'b0);
         pgHoldLow = 1'b0;
         cyc(5);
         chk(moduleReset_n === 1'b1);
      end
   endtask
   task t_deep(input [1:0] s, input ctx, input sup);
      begin
         enter(s);
         chk(sleepState === s && contextKept === ctx && main_supply_on_n === sup);
         deepSleepEn = 1'b1;
         cyc(2);
         chk(deepSleepActive === 1'b1 && contextKept === ctx);
         deepSleepEn = 1'b0;
         wake;
         chk(deepSleepActive === 1'b0 && sleepState === s);
      end
   endtask
   task t_refuse;
      begin
         repeat (20) if (moduleReset_n !== 1'b1) cyc(1);
         enter(`MPC_SX_S0);
         chk(sleepState === `MPC_SX_S0 && moduleReset_n === 1'b1);
         wake;
         chk(sleepState === `MPC_SX_S0 && main_supply_on_n === 1'b0);
      end
   endtask
   task t_force;
      begin
         pressReq = 1'b1;
         cyc(6);
         chk(main_supply_on_n === 1'b0 && sleepState === `MPC_SX_S0);
         cyc(5);
         chk(main_supply_on_n === 1'b1 && sleepState === `MPC_SX_S5);
         pressReq = 1'b0;
         cyc(3);
      end
   endtask
   task t_soft_off;
      begin
         enter(`MPC_SX_S5);
         chk(main_supply_on_n === 1'b1 && sleepState === `MPC_SX_S5);
         chk(moduleReset_n === 1'b0);
         enter(`MPC_SX_S3);
         wake;
         chk(main_supply_on_n === 1'b1 && sleepState === `MPC_SX_S5);
      end
   endtask
   initial begin
      cyc(16);
      arst_n = 1'b1;
      cyc(2);
      t_power_up;
      t_pg_drop;
      t_deep(`MPC_SX_S3, 1'b1, 1'b0);
      wake;
      chk(sleepState === `MPC_SX_S0);
      cyc(3);
      buttonOffEn = 1'b1;
      press;
      chk(main_supply_on_n === 1'b1 && sleepState === `MPC_SX_S5);
      buttonOffEn = 1'b0;
      t_power_up;
      t_deep(`MPC_SX_S4, 1'b0, 1'b1);
      wake;
      chk(sleepState === `MPC_SX_S0 && main_supply_on_n === 1'b0);
      t_refuse;
      t_force;
      t_power_up;
      t_soft_off;
      arst_n = 1'b0;
      cyc(2);
      chk(main_supply_on_n === 1'b1 && sleepState === `MPC_SX_S5);
      chk(moduleReset_n === 1'b0);
      arst_n = 1'b1;
      cyc(2);
      t_power_up;
      finish_test;
   end
endmodule

//--- mpc_regs.vh
`ifndef MPC_REGS_VH
`define MPC_REGS_VH
// Contract
// R01: The carrier holds power-good low until all its rails and clocks are stable.
// R02: A high power-good level lets the module start its own power sequencing.
// R03: The module stays in reset while power-good is held low.
// R04: The carrier should release power-good about 100 ms after its rails are up. The carrier model raises it PG_DLY clocks after supply-on.
// R05: The carrier should drive power-good low for reset and tri-state it when ready. The carrier model drives it high when ready.
// R06: The module still sequences when power-good is left undriven (reads high).
// R07: The module drives an active-low supply-on output to switch on the main supply.
// R08: The carrier inverts the supply-on output from standby power before the supply.
// R09: The carrier presents the power button as a debounced active-low contact.
// R10: A power-button press requests power on or off, as configured.
// R11: In deep sleep all power is removed except minimal wake logic.
// R12: Deep sleep keeps context or not according to its entry condition.
// R13: Resume from deep sleep returns to the sleep state it was entered from.
// R14: The module supports suspend-to-RAM.
// R15: Power-good and power-button pass a two-stage synchronizer before use.

// Sleep state codes
`define MPC_SX_S0        2'h0
`define MPC_SX_S3        2'h1
`define MPC_SX_S4        2'h2
`define MPC_SX_S5        2'h3
// Time from supply-on to rails assumed up
`define MPC_RAIL_US      1000
`define MPC_CLK_MHZ      50
`define MPC_RAIL_CYC     (`MPC_RAIL_US * `MPC_CLK_MHZ)
// Button hold for forced off, 4 s
`define MPC_FORCE_MS     4000
`define MPC_FORCE_CYC    (`MPC_FORCE_MS * 1000 * `MPC_CLK_MHZ)
`endif

//--- mpc_sync2.v
`timescale 1ns/1ps
module mpc_sync2 #(
   parameter RESET_VAL = 1'b0
) (
   input  wire ref_clk,
   input  wire arst_n,
   input  wire din,
   output wire dout
);
   reg stage1_reg;
   reg stage2_reg;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_reg <= RESET_VAL;
         stage2_reg <= RESET_VAL;
      end else begin
         stage1_reg <= din;
         stage2_reg <= stage1_reg;
      end
   end
   assign dout = stage2_reg;
endmodule
